//--- hw/rin_pkg.sv
// register map, field positions and constants of the rx if/notch control
package rin_pkg;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [7:0] BAND_AND_MODE_CONTROL_ADDR = 8'h0A;
  localparam logic [7:0] NOTCH_HIGH_THRESHOLD_A_ADDR = 8'h0D;
  localparam logic [7:0] RECEIVER_GAIN_AND_IF_SELECT_ADDR = 8'h0E;
  localparam logic [7:0] DETECTION_ENABLES_ADDR = 8'h0F;
  localparam logic [7:0] FILTER_AND_DETECTOR_SELECT_ADDR = 8'h10;
  localparam logic [7:0] NOTCH_SECOND_HIGH_THRESHOLDS_ADDR = 8'h12;
  localparam logic [7:0] NOTCH_HIGH_THRESHOLD_B_ADDR = 8'h13;
  localparam logic [7:0] DETECTION_INTERVAL_CONTROL_ADDR = 8'h1A;
  localparam logic [7:0] NOTCH_FREQUENCY_CONTROL_ADDR = 8'h1B;
  localparam logic [7:0] NOTCH_LOW_THRESHOLDS_ADDR = 8'h1C;

  // ****************************************
  // reset values and field positions
  // ****************************************
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  localparam int TX_SELECT_BIT = 5;
  localparam int DEMOD_TYPE_BIT = 4;
  localparam int IF_BANDWIDTH_BIT = 5;
  localparam int NOTCH_ENABLE_BIT = 1;
  localparam int DETECTOR_TYPE_BIT = 0;
  localparam int NOTCH_FREQ_LO_BIT = 1;
  localparam int SECOND_HIGH_THR_0_BIT = 1;

  // ****************************************
  // frequencies in khz
  // ****************************************
  localparam logic [9:0] IF_FREQ_WIDE_KHZ = 10'd230;
  localparam logic [9:0] IF_FREQ_MID_KHZ = 10'd280;
  localparam logic [9:0] NOTCH_FREQ_0_KHZ = 10'd631;
  localparam logic [9:0] NOTCH_FREQ_1_KHZ = 10'd659;
  localparam logic [9:0] NOTCH_FREQ_2_KHZ = 10'd689;
  localparam logic [9:0] NOTCH_FREQ_3_KHZ = 10'd712;
  localparam logic [9:0] NOTCH_FREQ_NONE_KHZ = 10'd0;

  // notch validity policy
  typedef enum logic [1:0] {
    NOTCH_OFF,
    NOTCH_LATCHED,
    NOTCH_FOLLOW,
    NOTCH_ALWAYS
  } rin_notch_mode_type;

endpackage : rin_pkg

//--- hw/rin_ctrl.sv
// rx if select, demod select and interferer notch control
// Overview of operation
// - IF bit 0 gives 230 kHz wide filter, 1 gives 280 kHz middle filter.
// - Transmit bit set means transmit, else demod bit 0 FSK and 1 ASK.
// - The IF output takes the FSK or the ASK path per the demod choice.
// - The notch is active only in FSK receive with its enable bit 1, else bypassed.
// - An enabled notch sits at 631, 659, 689 or 712 kHz per its field.
// - Detector bit 0 selects delay detection, 1 pulse count detection.
// - Delay detection, intermittent: notch stays valid after interference.
// - Delay detection, continuous: notch valid only during interference.
// - Pulse count detection keeps the notch valid whenever the notch is active.
`timescale 1ns/1ps
module rin_ctrl (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic interf_det,
  output logic if_filter_mid,
  output logic [9:0] if_freq_khz,
  output logic tx_mode,
  output logic rx_fsk,
  output logic rx_ask,
  output logic det_pulse_count,
  output logic notch_enabled,
  output logic [9:0] notch_freq_khz,
  output logic notch_valid,
  output rin_pkg::rin_notch_mode_type notch_mode
);
  import rin_pkg::*;

  logic [7:0] band_and_mode_control;
  logic [7:0] notch_high_threshold_a;
  logic [7:0] receiver_gain_and_if_select;
  logic [7:0] detection_enables;
  logic [7:0] filter_and_detector_select;
  logic [7:0] notch_second_high_thresholds;
  logic [7:0] notch_high_threshold_b;
  logic [7:0] detection_interval_control;
  logic [7:0] notch_frequency_control;
  logic [7:0] notch_low_thresholds;
  logic interf_sync1;
  logic interf_sync2;
  logic interf_sync3;
  logic interf_level;
  logic interf_seen;
  logic next_rx_fsk;
  logic next_notch_on;
  rin_notch_mode_type next_notch_mode;

  function automatic logic [9:0] notch_khz(input logic [1:0] code);
    case (code)
      2'h0: notch_khz = NOTCH_FREQ_0_KHZ;
      2'h1: notch_khz = NOTCH_FREQ_1_KHZ;
      2'h2: notch_khz = NOTCH_FREQ_2_KHZ;
      default: notch_khz = NOTCH_FREQ_3_KHZ;
    endcase
  endfunction : notch_khz

  // ****************************************
  // register file
  // ****************************************
  // hold until rewritten
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      band_and_mode_control <= REG_RESET;
      notch_high_threshold_a <= REG_RESET;
      receiver_gain_and_if_select <= REG_RESET;
      detection_enables <= REG_RESET;
      filter_and_detector_select <= REG_RESET;
      notch_second_high_thresholds <= REG_RESET;
      notch_high_threshold_b <= REG_RESET;
      detection_interval_control <= REG_RESET;
      notch_frequency_control <= REG_RESET;
      notch_low_thresholds <= REG_RESET;
    end else if (clk_en && reg_wr) begin
      case (reg_addr)
        BAND_AND_MODE_CONTROL_ADDR: band_and_mode_control <= reg_wdata;
        NOTCH_HIGH_THRESHOLD_A_ADDR: notch_high_threshold_a <= reg_wdata;
        RECEIVER_GAIN_AND_IF_SELECT_ADDR: begin
          receiver_gain_and_if_select <= reg_wdata;
        end
        DETECTION_ENABLES_ADDR: detection_enables <= reg_wdata;
        FILTER_AND_DETECTOR_SELECT_ADDR: begin
          filter_and_detector_select <= reg_wdata;
        end
        NOTCH_SECOND_HIGH_THRESHOLDS_ADDR: begin
          notch_second_high_thresholds <= reg_wdata;
        end
        NOTCH_HIGH_THRESHOLD_B_ADDR: notch_high_threshold_b <= reg_wdata;
        DETECTION_INTERVAL_CONTROL_ADDR: begin
          detection_interval_control <= reg_wdata;
        end
        NOTCH_FREQUENCY_CONTROL_ADDR: notch_frequency_control <= reg_wdata;
        NOTCH_LOW_THRESHOLDS_ADDR: notch_low_thresholds <= reg_wdata;
        default: ;
      endcase
    end
  end

  // registered read, unmapped offsets read as zero
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      reg_rdata <= UNMAPPED_READ;
    end else if (clk_en && reg_rd) begin
      case (reg_addr)
        BAND_AND_MODE_CONTROL_ADDR: reg_rdata <= band_and_mode_control;
        NOTCH_HIGH_THRESHOLD_A_ADDR: reg_rdata <= notch_high_threshold_a;
        RECEIVER_GAIN_AND_IF_SELECT_ADDR: begin
          reg_rdata <= receiver_gain_and_if_select;
        end
        DETECTION_ENABLES_ADDR: reg_rdata <= detection_enables;
        FILTER_AND_DETECTOR_SELECT_ADDR: begin
          reg_rdata <= filter_and_detector_select;
        end
        NOTCH_SECOND_HIGH_THRESHOLDS_ADDR: begin
          reg_rdata <= notch_second_high_thresholds;
        end
        NOTCH_HIGH_THRESHOLD_B_ADDR: reg_rdata <= notch_high_threshold_b;
        DETECTION_INTERVAL_CONTROL_ADDR: begin
          reg_rdata <= detection_interval_control;
        end
        NOTCH_FREQUENCY_CONTROL_ADDR: reg_rdata <= notch_frequency_control;
        NOTCH_LOW_THRESHOLDS_ADDR: reg_rdata <= notch_low_thresholds;
        default: reg_rdata <= UNMAPPED_READ;
      endcase
    end
  end

  // ****************************************
  // path selection
  // ****************************************
  always_comb begin
    next_rx_fsk = !band_and_mode_control[TX_SELECT_BIT] &&
                  !band_and_mode_control[DEMOD_TYPE_BIT];
    next_notch_on = next_rx_fsk &&
                    filter_and_detector_select[NOTCH_ENABLE_BIT];
    if (!next_notch_on) begin
      next_notch_mode = NOTCH_OFF;
    end else if (filter_and_detector_select[DETECTOR_TYPE_BIT]) begin
      next_notch_mode = NOTCH_ALWAYS;
    end else if (notch_second_high_thresholds[SECOND_HIGH_THR_0_BIT]) begin
      next_notch_mode = NOTCH_FOLLOW;
    end else begin
      next_notch_mode = NOTCH_LATCHED;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      if_filter_mid <= 1'b0;
      if_freq_khz <= IF_FREQ_WIDE_KHZ;
      tx_mode <= 1'b0;
      rx_fsk <= 1'b1;
      rx_ask <= 1'b0;
      det_pulse_count <= 1'b0;
      notch_enabled <= 1'b0;
      notch_freq_khz <= NOTCH_FREQ_NONE_KHZ;
      notch_mode <= NOTCH_OFF;
    end else if (clk_en) begin
      if_filter_mid <= receiver_gain_and_if_select[IF_BANDWIDTH_BIT];
      if_freq_khz <= receiver_gain_and_if_select[IF_BANDWIDTH_BIT] ?
                     IF_FREQ_MID_KHZ : IF_FREQ_WIDE_KHZ;
      tx_mode <= band_and_mode_control[TX_SELECT_BIT];
      rx_fsk <= next_rx_fsk;
      rx_ask <= !band_and_mode_control[TX_SELECT_BIT] &&
                band_and_mode_control[DEMOD_TYPE_BIT];
      det_pulse_count <= filter_and_detector_select[DETECTOR_TYPE_BIT];
      notch_enabled <= next_notch_on;
      notch_freq_khz <= next_notch_on ?
        notch_khz(notch_frequency_control[NOTCH_FREQ_LO_BIT +: 2]) :
        NOTCH_FREQ_NONE_KHZ;
      notch_mode <= next_notch_mode;
    end
  end

  // ****************************************
  // interference input and notch validity
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      interf_sync1 <= 1'b0;
      interf_sync2 <= 1'b0;
      interf_sync3 <= 1'b0;
      interf_level <= 1'b0;
    end else if (clk_en) begin
      interf_sync1 <= interf_det;
      interf_sync2 <= interf_sync1;
      interf_sync3 <= interf_sync2;
      if (interf_sync2 == interf_sync3) begin
        interf_level <= interf_sync3;
      end
    end
  end

  // latch until notch leaves latched mode, set wins
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      interf_seen <= 1'b0;
    end else if (clk_en) begin
      if (notch_mode == NOTCH_LATCHED && interf_level) begin
        interf_seen <= 1'b1;
      end else if (notch_mode != NOTCH_LATCHED) begin
        interf_seen <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      notch_valid <= 1'b0;
    end else if (clk_en) begin
      case (notch_mode)
        NOTCH_ALWAYS: notch_valid <= 1'b1;
        NOTCH_FOLLOW: notch_valid <= interf_level;
        NOTCH_LATCHED: notch_valid <= interf_level || interf_seen;
        default: notch_valid <= 1'b0;
      endcase
    end
  end

  // ****************************************
  // checks
  // ****************************************
  if_select_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    clk_en |=> (if_freq_khz ==
      (if_filter_mid ? IF_FREQ_MID_KHZ : IF_FREQ_WIDE_KHZ)))
    else $error("if frequency does not match filter");
  tx_override_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    tx_mode |-> (!rx_fsk && !rx_ask))
    else $error("receive path active in transmit");
  path_onehot_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !tx_mode |-> (rx_fsk != rx_ask))
    else $error("demod path not exclusive");
  notch_gate_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (clk_en && !filter_and_detector_select[NOTCH_ENABLE_BIT]) ##1
      (clk_en && !filter_and_detector_select[NOTCH_ENABLE_BIT])
      |=> !notch_valid && !notch_enabled)
    else $error("notch active while disabled");
  notch_freq_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (notch_enabled &&
     notch_frequency_control[NOTCH_FREQ_LO_BIT +: 2] == 2'h3 &&
     $stable(notch_frequency_control) && $past(clk_en))
      |-> notch_freq_khz == NOTCH_FREQ_3_KHZ)
    else $error("notch frequency wrong");
  det_select_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    clk_en |=> det_pulse_count ==
      $past(filter_and_detector_select[DETECTOR_TYPE_BIT]))
    else $error("detector select not followed");
  // validity carried over from another mode is not a latch
  latch_hold_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (notch_mode == NOTCH_LATCHED && clk_en) ##1
      (notch_mode == NOTCH_LATCHED && notch_valid && clk_en) ##1
      (notch_mode == NOTCH_LATCHED && clk_en) |=> notch_valid)
    else $error("latched notch dropped");
  follow_det_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (notch_mode == NOTCH_FOLLOW && clk_en) |=> notch_valid ==
      $past(interf_level))
    else $error("follow notch mismatch");
  always_valid_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (notch_mode == NOTCH_ALWAYS && clk_en) |=> notch_valid)
    else $error("pulse count notch not valid");
  reg_hold_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !(clk_en && reg_wr) |=> $stable(filter_and_detector_select))
    else $error("register changed without write");

endmodule : rin_ctrl

//--- test/test_rx_if_demod_notch_control.sv
// self-checking bench of the rx if, demod and notch control block
`timescale 1ns/1ps
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin \
  miscompares++; $display("BAD %0t got %0h want %0h", $time, got, exp); end end
module test_rx_if_demod_notch_control;
  import rin_pkg::*;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic clk_en = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic interf_det = 1'b0;
  logic if_filter_mid, tx_mode, rx_fsk, rx_ask, det_pulse_count;
  logic notch_enabled, notch_valid;
  logic [9:0] if_freq_khz, notch_freq_khz;
  rin_notch_mode_type notch_mode;
  int miscompares = 0;
  int checks = 0;
  logic [7:0] got, d;
  logic [7:0] addrs [10] = '{8'h0A, 8'h0D, 8'h0E, 8'h0F, 8'h10, 8'h12,
    8'h13, 8'h1A, 8'h1B, 8'h1C};

  rin_ctrl uut (.sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .interf_det(interf_det),
    .if_filter_mid(if_filter_mid), .if_freq_khz(if_freq_khz),
    .tx_mode(tx_mode), .rx_fsk(rx_fsk), .rx_ask(rx_ask),
    .det_pulse_count(det_pulse_count), .notch_enabled(notch_enabled),
    .notch_freq_khz(notch_freq_khz), .notch_valid(notch_valid),
    .notch_mode(notch_mode));

  initial begin
    forever #10 sys_clk = ~sys_clk;
  end

  function automatic logic [9:0] want_notch(logic en, logic [1:0] code);
    logic [9:0] f [4] = '{10'd631, 10'd659, 10'd689, 10'd712};
    return en ? f[code] : 10'd0;
  endfunction : want_notch

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    #1;
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(posedge sys_clk);
    #1;
    reg_wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge sys_clk);
    #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge sys_clk);
    #1;
    reg_rd = 1'b0;
    v = reg_rdata;
  endtask : rd

  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : settle

  task automatic results;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : results

  initial begin
    #1_000_000;
    miscompares++;
    results();
  end

  initial begin
    void'($urandom(65));
    settle(2);
    reset_n = 1'b1;
    rd(8'h10, got);
    `CHK(got, 8'h00)
    `CHK({rx_fsk, rx_ask, tx_mode, notch_valid}, 4'b1000)
    // random store and readback, unmapped place reads zero
    for (int i = 0; i < 20; i++) begin
      d = 8'($urandom);
      wr(addrs[i % 10], d);
      rd(addrs[i % 10], got);
      `CHK(got, d)
    end
    wr(8'h11, 8'hFF);
    rd(8'h11, got);
    `CHK(got, 8'h00)
    for (int b = 0; b < 2; b++) begin
      wr(8'h0E, {2'($urandom), b[0], 5'($urandom)});
      settle(2);
      `CHK(if_filter_mid, b[0])
      `CHK(if_freq_khz, b[0] ? 10'd280 : 10'd230)
    end
    for (int m = 0; m < 4; m++) begin
      wr(8'h0A, {2'b00, m[1:0], 4'($urandom)});
      settle(2);
      `CHK(tx_mode, m[1])
      `CHK({rx_fsk, rx_ask}, m[1] ? 2'b00 : {~m[0], m[0]})
    end
    // every notch code, enabled then bypassed
    wr(8'h0A, 8'h00);
    for (int e = 1; e >= 0; e--) begin
      wr(8'h10, {6'h00, e[0], 1'b0});
      for (int c = 0; c < 4; c++) begin
        wr(8'h1B, {5'h00, c[1:0], 1'b1});
        settle(2);
        `CHK(notch_enabled, e[0])
        `CHK(notch_freq_khz, want_notch(e[0], c[1:0]))
      end
    end
    // host threshold set for delay detection, intermittent
    wr(8'h0F, 8'h01);
    wr(8'h1C, 8'h02);
    wr(8'h12, 8'h00);
    wr(8'h10, 8'h02);
    settle(2);
    `CHK(det_pulse_count, 1'b0)
    `CHK(notch_mode, NOTCH_LATCHED)
    `CHK(notch_valid, 1'b0)
    interf_det = 1'b1;
    settle(6);
    interf_det = 1'b0;
    settle(6);
    `CHK(notch_valid, 1'b1)
    // clk_en low: write not taken
    clk_en = 1'b0;
    wr(8'h12, 8'h02);
    clk_en = 1'b1;
    rd(8'h12, got);
    `CHK(got, 8'h00)
    wr(8'h12, 8'h02);
    settle(2);
    `CHK(notch_mode, NOTCH_FOLLOW)
    `CHK(notch_valid, 1'b0)
    interf_det = 1'b1;
    settle(6);
    `CHK(notch_valid, 1'b1)
    interf_det = 1'b0;
    settle(6);
    `CHK(notch_valid, 1'b0)
    // pulse count thresholds, notch always valid
    wr(8'h0F, 8'h00);
    wr(8'h1C, 8'h04);
    wr(8'h12, 8'h00);
    wr(8'h10, 8'h03);
    settle(2);
    `CHK(det_pulse_count, 1'b1)
    `CHK(notch_mode, NOTCH_ALWAYS)
    `CHK(notch_valid, 1'b1)
    wr(8'h0A, 8'h10);
    settle(2);
    `CHK(notch_enabled, 1'b0)
    results();
  end
endmodule : test_rx_if_demod_notch_control
